// file: rtl/mcd_dr_pulse.v
// data-ready pulse generator driven by processing-cycle events
`timescale 1ns/10ps
module mcd_dr_pulse #(
	parameter CNT_W = 16
) (
	input wire core_clk,
	input wire rst_b,
	input wire cycle_done,
	input wire [CNT_W-1:0] period_cyc,
	output reg dr_active_ff
);
	reg [CNT_W-1:0] cnt_ff;
	reg [CNT_W-1:0] nxt_cnt;
	reg nxt_active;
	wire [CNT_W-1:0] low_at;

	// drop point at a quarter of the period, inside the 15..35 percent band
	assign low_at = {2'b00, period_cyc[CNT_W-1:2]};

	// set on cycle end, clear partway through the next cycle
	always @* begin
		nxt_cnt = cnt_ff;
		nxt_active = dr_active_ff;
		if (cycle_done) begin
			nxt_active = 1'b1;
			nxt_cnt = {CNT_W{1'b0}};
		end else if (dr_active_ff) begin
			nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
			if (cnt_ff >= low_at)
				nxt_active = 1'b0;
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= {CNT_W{1'b0}};
			dr_active_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			dr_active_ff <= nxt_active;
		end
	end
endmodule // mcd_dr_pulse

// file: rtl/mcd_map.vh
// register map, field positions and timing constants of the control block
`ifndef MCD_MAP_VH
`define MCD_MAP_VH
`define MCD_ADR_DAC_LO 8'h30
`define MCD_ADR_DAC_HI 8'h31
`define MCD_ADR_MSC_LO 8'h34
`define MCD_ADR_MSC_HI 8'h35
`define MCD_ADR_STAT_LO 8'h3C
`define MCD_ADR_STAT_HI 8'h3D
`define MCD_ADR_CMD_LO 8'h3E
`define MCD_ADR_CMD_HI 8'h3F
`define MCD_ADR_SMPL_LO 8'h36
`define MCD_ADR_ADC_LO 8'h38
`define MCD_ADR_ADC_HI 8'h39
`define MCD_MSC_DR_SEL 0
`define MCD_MSC_DR_POL 1
`define MCD_MSC_DR_EN 2
`define MCD_MSC_ST_EN 0
`define MCD_MSC_REV 1
`define MCD_MSC_NO_PST 2
`define MCD_CMD_LATCH 2
`define MCD_CMD_CLR 4
`define MCD_STAT_ST_FAIL 5
`define MCD_DAC_HI_MASK 8'h0F
`define MCD_RST_BYTE 8'h00
`define MCD_RST_DAC 12'h000
`define MCD_RST_SMPL 8'h01
`define MCD_ST_SMPL 8'h00
`define MCD_INCL_ST 14'h05C8
`define MCD_ANGLE_FULL 14'h3840
`define MCD_CLK_MHZ 100
`define MCD_PST_HP_US 13000
`define MCD_PST_LP_US 35000
`define MCD_PST_HP_CYC (`MCD_PST_HP_US * `MCD_CLK_MHZ)
`define MCD_PST_LP_CYC (`MCD_PST_LP_US * `MCD_CLK_MHZ)
`endif

// file: rtl/mcd_misc_ctrl.v
// miscellaneous control and dac latch register bank
`timescale 1ns/10ps
`include "mcd_map.vh"
module mcd_misc_ctrl #(
	parameter PST_HP_CYC = `MCD_PST_HP_CYC,
	parameter PST_LP_CYC = `MCD_PST_LP_CYC,
	parameter ST_CYC = 32'd1000,
	parameter CNT_W = 16
) (
	input wire core_clk,
	input wire rst_b,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_ff,
	input wire [2:0] nv_dr_cfg,
	output wire [2:0] nv_dr_cfg_out,
	input wire low_power,
	input wire cycle_done,
	input wire [CNT_W-1:0] period_cyc,
	input wire st_fail_event,
	input wire [13:0] incl_raw,
	output reg [13:0] incl_out_ff,
	output wire st_active,
	input wire [7:0] sample_period_in,
	output wire [7:0] sample_period_reg,
	input wire [11:0] adc_result,
	input wire alm_en,
	input wire alm_sel,
	input wire alm_level,
	input wire [1:0] gpio_dir,
	input wire [1:0] gpio_level,
	output wire aux_pin_zero_o,
	output wire aux_pin_zero_oe_b,
	output wire aux_pin_one_o,
	output wire aux_pin_one_oe_b,
	output reg [11:0] dac_code_ff,
	output wire [15:0] status_out
);
	localparam ST_IDLE = 2'b00;
	localparam ST_PWRUP = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [2:0] dr_cfg_ff;
	reg [2:0] st_cfg_ff;
	reg [7:0] dac_lo_ff;
	reg [3:0] dac_hi_ff;
	reg st_fail_ff;
	reg [7:0] smpl_save_ff;
	reg [7:0] smpl_ff;
	reg [1:0] st_state_ff;
	reg [1:0] nxt_st_state;
	reg [31:0] st_cnt_ff;
	reg [31:0] nxt_st_cnt;
	reg cfg_load_ff;
	reg [11:0] adc_ff;
	reg pin0_o;
	reg pin0_oe;
	reg pin1_o;
	reg pin1_oe;
	wire dr_active;
	wire dr_level;
	wire wr_cmd;
	wire st_busy;
	wire st_start;
	wire [31:0] pst_cyc;

	// register write decode helper
	function hit;
		input [7:0] a;
		input [7:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	assign wr_cmd = reg_wr && hit(reg_addr, `MCD_ADR_CMD_LO);
	assign pst_cyc = low_power ? PST_LP_CYC : PST_HP_CYC;

	// data-ready configuration, restored from the saved copy after reset
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dr_cfg_ff <= 3'b000;
			cfg_load_ff <= 1'b1;
		end else if (cfg_load_ff) begin
			dr_cfg_ff <= nv_dr_cfg;
			cfg_load_ff <= 1'b0;
		end else if (reg_wr && hit(reg_addr, `MCD_ADR_MSC_LO)) begin
			dr_cfg_ff <= reg_wdata[2:0];
		end
	end
	assign nv_dr_cfg_out = dr_cfg_ff;

	// self-test control bits are volatile
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_cfg_ff <= 3'b000;
		end else if (reg_wr && hit(reg_addr, `MCD_ADR_MSC_HI)) begin
			st_cfg_ff <= reg_wdata[2:0];
		end else if (st_state_ff == ST_RUN && !st_cfg_ff[`MCD_MSC_ST_EN] && st_cnt_ff == 32'd0) begin
			st_cfg_ff <= st_cfg_ff;
		end
	end

	// dac bytes stored without touching the output
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dac_lo_ff <= `MCD_RST_BYTE;
			dac_hi_ff <= 4'h0;
		end else if (reg_wr && hit(reg_addr, `MCD_ADR_DAC_LO)) begin
			dac_lo_ff <= reg_wdata;
		end else if (reg_wr && hit(reg_addr, `MCD_ADR_DAC_HI)) begin
			dac_hi_ff <= reg_wdata[3:0];
		end
	end

	// both bytes move together so no half-updated code appears
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dac_code_ff <= `MCD_RST_DAC;
		end else if (wr_cmd && reg_wdata[`MCD_CMD_LATCH]) begin
			dac_code_ff <= {dac_hi_ff, dac_lo_ff};
		end
	end

	// self-test sequencer: power-up run, then continuous when enabled
	always @* begin
		nxt_st_state = st_state_ff;
		nxt_st_cnt = st_cnt_ff;
		case (st_state_ff)
		ST_PWRUP: begin
			if (st_cnt_ff == 32'd0) begin
				nxt_st_state = ST_IDLE;
			end else begin
				nxt_st_cnt = st_cnt_ff - 32'd1;
			end
		end
		ST_RUN: begin
			if (!st_cfg_ff[`MCD_MSC_ST_EN]) begin
				nxt_st_state = ST_IDLE;
			end else if (st_cnt_ff == 32'd0) begin
				nxt_st_cnt = ST_CYC;
			end else begin
				nxt_st_cnt = st_cnt_ff - 32'd1;
			end
		end
		ST_IDLE: begin
			if (st_cfg_ff[`MCD_MSC_ST_EN]) begin
				nxt_st_state = ST_RUN;
				nxt_st_cnt = ST_CYC;
			end
		end
		default: begin
			nxt_st_state = ST_IDLE;
		end
		endcase
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_state_ff <= ST_IDLE;
			st_cnt_ff <= 32'd0;
		end else if (cfg_load_ff) begin
			// skip bit is cleared by reset, so the power-up test always runs
			st_state_ff <= st_cfg_ff[`MCD_MSC_NO_PST] ? ST_IDLE : ST_PWRUP;
			st_cnt_ff <= pst_cyc;
		end else begin
			st_state_ff <= nxt_st_state;
			st_cnt_ff <= nxt_st_cnt;
		end
	end
	assign st_busy = (st_state_ff != ST_IDLE);
	assign st_active = st_busy;
	// power-up entry bypasses the sequencer, so it must start the test too
	assign st_start = cfg_load_ff ? !st_cfg_ff[`MCD_MSC_NO_PST] : (!st_busy && nxt_st_state != ST_IDLE);

	// sample period shortened during test and put back afterwards
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			smpl_ff <= `MCD_RST_SMPL;
			smpl_save_ff <= `MCD_RST_SMPL;
		end else if (st_start) begin
			smpl_save_ff <= sample_period_in;
			smpl_ff <= `MCD_ST_SMPL;
		end else if (st_busy && nxt_st_state == ST_IDLE) begin
			smpl_ff <= smpl_save_ff;
		end else if (!st_busy) begin
			smpl_ff <= sample_period_in;
		end
	end
	assign sample_period_reg = smpl_ff;

	// fail flag: a new failure wins over a clear in the same cycle
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_fail_ff <= 1'b0;
		end else if (st_busy && st_fail_event) begin
			st_fail_ff <= 1'b1;
		end else if (wr_cmd && reg_wdata[`MCD_CMD_CLR]) begin
			st_fail_ff <= 1'b0;
		end
	end
	assign status_out = {10'h000, st_fail_ff, 5'h00};

	// inclination output: fixed angle in test, mirrored when reversed
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			incl_out_ff <= 14'h0000;
		end else if (st_busy) begin
			incl_out_ff <= `MCD_INCL_ST;
		end else if (st_cfg_ff[`MCD_MSC_REV] && incl_raw != 14'h0000) begin
			incl_out_ff <= `MCD_ANGLE_FULL - incl_raw;
		end else begin
			incl_out_ff <= incl_raw;
		end
	end

	// adc result held as plain 12-bit binary
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			adc_ff <= 12'h000;
		end else begin
			adc_ff <= adc_result;
		end
	end

	mcd_dr_pulse #(
		.CNT_W(CNT_W)
	) u_dr (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.cycle_done(cycle_done),
		.period_cyc(period_cyc),
		.dr_active_ff(dr_active)
	);

	assign dr_level = dr_cfg_ff[`MCD_MSC_DR_POL] ? dr_active : !dr_active;

	// pin arbitration by priority; lower owners take over when released
	always @* begin
		pin0_o = gpio_level[0];
		pin0_oe = gpio_dir[0];
		pin1_o = gpio_level[1];
		pin1_oe = gpio_dir[1];
		if (alm_en && !alm_sel) begin
			pin0_o = alm_level;
			pin0_oe = 1'b1;
		end
		if (alm_en && alm_sel) begin
			pin1_o = alm_level;
			pin1_oe = 1'b1;
		end
		if (dr_cfg_ff[`MCD_MSC_DR_EN]) begin
			if (dr_cfg_ff[`MCD_MSC_DR_SEL]) begin
				pin1_o = dr_level;
				pin1_oe = 1'b1;
			end else begin
				pin0_o = dr_level;
				pin0_oe = 1'b1;
			end
		end
	end
	assign aux_pin_zero_o = pin0_o;
	assign aux_pin_zero_oe_b = !pin0_oe;
	assign aux_pin_one_o = pin1_o;
	assign aux_pin_one_oe_b = !pin1_oe;

	// read mux; unmapped and write-only bytes read zero
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`MCD_ADR_DAC_LO: reg_rdata_ff <= dac_lo_ff;
			`MCD_ADR_DAC_HI: reg_rdata_ff <= {4'h0, dac_hi_ff};
			`MCD_ADR_MSC_LO: reg_rdata_ff <= {5'h00, dr_cfg_ff};
			`MCD_ADR_MSC_HI: reg_rdata_ff <= {5'h00, st_cfg_ff};
			`MCD_ADR_STAT_LO: reg_rdata_ff <= status_out[7:0];
			`MCD_ADR_ADC_LO: reg_rdata_ff <= adc_ff[7:0];
			`MCD_ADR_ADC_HI: reg_rdata_ff <= {4'h0, adc_ff[11:8]};
			default: reg_rdata_ff <= 8'h00;
			endcase
		end
	end
endmodule // mcd_misc_ctrl

// file: tb/mcd_host.sv
// host model: byte strobe register master
`timescale 1ns/10ps
module mcd_host (
	input wire core_clk,
	input wire [7:0] reg_rdata_ff,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one byte write; released lines never keep the last value
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// one byte read, answer taken a cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge core_clk);
		#1 d = reg_rdata_ff;
	endtask
	// latch only after both code bytes are loaded
	task latch;
		wr(8'h3E, 8'h04);
	endtask
endmodule // mcd_host

// file: tb/mcd_misc_ctrl_sva.sv
// assertion checker for the control block ports
`timescale 1ns/10ps
module mcd_chk (
	input wire core_clk,
	input wire rst_b,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata_ff,
	input wire [2:0] nv_dr_cfg_out,
	input wire st_fail_event,
	input wire [13:0] incl_out_ff,
	input wire st_active,
	input wire [7:0] sample_period_reg,
	input wire cycle_done,
	input wire aux_pin_one_o,
	input wire aux_pin_one_oe_b,
	input wire [11:0] dac_code_ff,
	input wire [15:0] status_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// latch command seen on the byte bus
	wire latch_w = reg_wr && reg_addr == 8'h3E && reg_wdata[2];
	property p_dac_hold;
		!latch_w |=> $stable(dac_code_ff);
	endproperty
	a_dac_hold: assert property (p_dac_hold) else $error("dac moved without latch");
	property p_rd_cmd;
		reg_rd && reg_addr == 8'h3E |-> ##2 reg_rdata_ff == 8'h00;
	endproperty
	a_rd_cmd: assert property (p_rd_cmd) else $error("command read not zero");
	property p_incl_st;
		st_active [*2] |-> incl_out_ff == 14'h05C8;
	endproperty
	a_incl_st: assert property (p_incl_st) else $error("test angle wrong");
	property p_smpl_st;
		st_active [*2] |-> sample_period_reg == 8'h00;
	endproperty
	a_smpl_st: assert property (p_smpl_st) else $error("test period wrong");
	property p_pst_start;
		$rose(rst_b) |-> ##[0:3] st_active;
	endproperty
	a_pst_start: assert property (p_pst_start) else $error("no test after reset");
	property p_dr_sel;
		nv_dr_cfg_out[2] && nv_dr_cfg_out[0] |-> !aux_pin_one_oe_b;
	endproperty
	a_dr_sel: assert property (p_dr_sel) else $error("pin one not driven");
	property p_dr_rise;
		cycle_done && nv_dr_cfg_out == 3'h7 ##1 nv_dr_cfg_out == 3'h7 |-> aux_pin_one_o;
	endproperty
	a_dr_rise: assert property (p_dr_rise) else $error("ready not raised");
	property p_st_fail;
		st_fail_event && st_active |=> status_out[5];
	endproperty
	a_st_fail: assert property (p_st_fail) else $error("fail flag not set");
	c_latch: cover property (latch_w);
	c_fail: cover property (st_fail_event && st_active);
	c_ready: cover property ($rose(aux_pin_one_o));
endmodule // mcd_chk
bind mcd_misc_ctrl mcd_chk chk_u (.core_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata_ff, .nv_dr_cfg_out, .st_fail_event, .incl_out_ff, .st_active,
	.sample_period_reg, .cycle_done, .aux_pin_one_o, .aux_pin_one_oe_b, .dac_code_ff,
	.status_out);

// file: tb/mcd_misc_ctrl_tb_top.sv
// self-checking bench for the control block
`timescale 1ns/10ps
module mcd_misc_ctrl_tb_top;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cycle_done = 1'b0;
	logic st_fail_event = 1'b0;
	logic alm_en = 1'b0;
	logic alm_sel = 1'b1;
	logic alm_level = 1'b1;
	logic [1:0] gpio_dir = 2'h0;
	logic [1:0] gpio_level = 2'h3;
	logic [13:0] incl_raw = 14'h0100;
	logic low_power = 1'b0;
	logic [2:0] nv_dr_cfg = 3'h0;
	logic [7:0] sample_period_in = 8'h5A;
	logic reg_wr, reg_rd, st_active;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, rd_v, sample_period_reg;
	logic [2:0] nv_dr_cfg_out;
	logic [13:0] incl_out_ff;
	logic [11:0] dac_code_ff;
	logic [15:0] status_out;
	wire aux_pin_zero_o, aux_pin_zero_oe_b, aux_pin_one_o, aux_pin_one_oe_b;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #5 core_clk = ~core_clk;
	// long power-up counts shortened so the run stays brief
	mcd_misc_ctrl #(.PST_HP_CYC(50), .PST_LP_CYC(50), .ST_CYC(32'd20)) dut_u (
		.core_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff,
		.nv_dr_cfg, .nv_dr_cfg_out, .low_power, .cycle_done,
		.period_cyc(16'h0010), .st_fail_event, .incl_raw, .incl_out_ff, .st_active,
		.sample_period_in, .sample_period_reg, .adc_result(12'hABC), .alm_en,
		.alm_sel, .alm_level, .gpio_dir, .gpio_level, .aux_pin_zero_o, .aux_pin_zero_oe_b,
		.aux_pin_one_o, .aux_pin_one_oe_b, .dac_code_ff, .status_out);
	mcd_host host_u (.core_clk, .reg_rdata_ff, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task pulse_done;
		@(posedge core_clk);
		cycle_done <= 1'b1;
		@(posedge core_clk);
		cycle_done <= 1'b0;
	endtask
	// hang guard, whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk(st_active, 1'b1);
		chk(incl_out_ff, 14'h05C8);
		chk(sample_period_reg, 8'h00);
		repeat (60) @(posedge core_clk);
		#1 chk(st_active, 1'b0);
		chk(sample_period_reg, 8'h5A);
		chk(incl_out_ff, 14'h0100);
		host_u.rd(8'h30, rd_v);
		chk(rd_v, 8'h00);
		host_u.rd(8'h35, rd_v);
		chk(rd_v, 8'h00);
		$display("reset test done");
		host_u.wr(8'h30, 8'hAB);
		host_u.wr(8'h31, 8'hFC);
		#1 chk(dac_code_ff, 12'h000);
		host_u.rd(8'h31, rd_v);
		chk(rd_v, 8'h0C);
		host_u.latch();
		@(posedge core_clk);
		#1 chk(dac_code_ff, 12'hCAB);
		$display("dac test done");
		// alarm also claims pin one, ready must win
		host_u.wr(8'h34, 8'h07);
		alm_en <= 1'b1;
		pulse_done();
		#1 chk(nv_dr_cfg_out, 3'h7);
		chk({aux_pin_one_oe_b, aux_pin_one_o}, 2'b01);
		chk(aux_pin_zero_oe_b, 1'b1);
		repeat (8) @(posedge core_clk);
		#1 chk({aux_pin_one_oe_b, aux_pin_one_o}, 2'b00);
		host_u.wr(8'h34, 8'h04);
		@(posedge core_clk);
		#1 chk({aux_pin_zero_oe_b, aux_pin_zero_o}, 2'b01);
		pulse_done();
		#1 chk(aux_pin_zero_o, 1'b0);
		host_u.wr(8'h34, 8'h01);
		@(posedge core_clk);
		#1 chk({aux_pin_one_oe_b, aux_pin_one_o}, 2'b01);
		@(posedge core_clk);
		alm_en <= 1'b0;
		gpio_dir <= 2'h2;
		gpio_level <= 2'h0;
		@(posedge core_clk);
		#1 chk({aux_pin_one_oe_b, aux_pin_one_o}, 2'b00);
		$display("ready test done");
		host_u.wr(8'h35, 8'h02);
		repeat (2) @(posedge core_clk);
		#1 chk(incl_out_ff, 14'h3740);
		host_u.wr(8'h35, 8'h01);
		// failure only counts once the test is running
		@(posedge core_clk);
		st_fail_event <= 1'b1;
		@(posedge core_clk);
		st_fail_event <= 1'b0;
		@(posedge core_clk);
		#1 chk(st_active, 1'b1);
		chk(incl_out_ff, 14'h05C8);
		host_u.rd(8'h3C, rd_v);
		chk(rd_v, 8'h20);
		host_u.wr(8'h35, 8'h00);
		host_u.wr(8'h3E, 8'h10);
		host_u.rd(8'h3C, rd_v);
		chk(rd_v, 8'h00);
		host_u.rd(8'h38, rd_v);
		chk(rd_v, 8'hBC);
		host_u.rd(8'h3E, rd_v);
		chk(rd_v, 8'h00);
		$display("self test done");
		// mid-run reset: saved ready config comes back, volatile state clears
		nv_dr_cfg <= 3'h5;
		low_power <= 1'b1;
		sample_period_in <= 8'h33;
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk(nv_dr_cfg_out, 3'h5);
		chk(dac_code_ff, 12'h000);
		chk(st_active, 1'b1);
		chk(sample_period_reg, 8'h00);
		repeat (60) @(posedge core_clk);
		#1 chk(st_active, 1'b0);
		chk(sample_period_reg, 8'h33);
		$display("reset rerun done");
		tally_and_finish();
	end
endmodule // mcd_misc_ctrl_tb_top
